/* File: logic/filter_port_pkg.sv */
// Constants for the filter serial control port
// Contract
// - Packets travel most significant bit first; D7 arrives first.
// - Serial data shifts into an eight-bit control shift register.
// - Bits D7..D4 are the address field; D7 is ignored.
// - Bits D3..D0 are the data nibble for the addressed register.
// - Serial data is sampled on each falling shift clock edge.
// - Shifting happens only while the load enable is high.
// - Enable falling latches the packet and applies it at once; here the codes change on the sixth rising system clock edge after the fall.
// - Boost code is upper D2..D0 over lower D3..D0.
// - Cutoff code is upper D2..D0 over lower D3..D0.
// - Power register uses only D0; one powers up, zero down.
// - Boost code drives the boost DAC, full scale at 127.
package filter_port_pkg;
   // ---------------------------------------------------------------
   // Packet layout
   // ---------------------------------------------------------------
   localparam int PACKET_BITS = 8;
   localparam int ADDR_MSB = 6;
   localparam int ADDR_LSB = 4;
   localparam int DATA_MSB = 3;
   localparam int DATA_LSB = 0;
   localparam int CODE_BITS = 7;
   localparam int BIT_COUNT_W = 4;
   // ---------------------------------------------------------------
   // Register addresses (D6..D4)
   // ---------------------------------------------------------------
   localparam logic [2:0] ADDR_BOOST_UPPER = 3'h0;
   localparam logic [2:0] ADDR_BOOST_LOWER = 3'h1;
   localparam logic [2:0] ADDR_CUTOFF_UPPER = 3'h2;
   localparam logic [2:0] ADDR_CUTOFF_LOWER = 3'h3;
   localparam logic [2:0] ADDR_POWER = 3'h7;
   // ---------------------------------------------------------------
   // Code limits
   // ---------------------------------------------------------------
   localparam logic [6:0] CUTOFF_CODE_MIN = 7'h15;
   localparam logic [6:0] CODE_FULL_SCALE = 7'h7f;
endpackage : filter_port_pkg

/* File: logic/packet_shifter.sv */
// Eight-bit falling-edge shift register for the serial link
`timescale 1ns/1ps
module packet_shifter #(
   parameter int WIDTH = filter_port_pkg::PACKET_BITS
) (
   input wire logic serialClock, // Link shift clock
   input wire logic serialLoadEnable, // High while a packet is shifted
   input wire logic serialDataIn, // Serial data, MSB first
   output logic [WIDTH-1:0] packet, // Shifted bits, newest in bit 0
   output logic [filter_port_pkg::BIT_COUNT_W-1:0] bitCount // Bits taken this window, saturating
);
   // ---------------------------------------------------------------
   // Shift on falling edge while enabled
   // ---------------------------------------------------------------
   always_ff @(negedge serialClock) begin
      if (serialLoadEnable) begin
         packet <= {packet[WIDTH-2:0], serialDataIn};
      end
   end

   // Window marker is cleared while the enable is low, because the link clock
   // stops between frames and a clocked copy would keep the old high level
   logic enableSeen;
   always_ff @(negedge serialClock or negedge serialLoadEnable) begin
      if (!serialLoadEnable) begin
         enableSeen <= 1'b0;
      end else begin
         enableSeen <= 1'b1;
      end
   end

   // Bit counter restarts on the first edge of a new window
   always_ff @(negedge serialClock) begin
      if (serialLoadEnable && !enableSeen) begin
         bitCount <= 4'h1;
      end else if (serialLoadEnable && bitCount != 4'hf) begin
         bitCount <= bitCount + 4'h1;
      end
   end
endmodule : packet_shifter

/* File: logic/filter_serial_control_port.sv */
// Filter serial control port: link shifter, latch and code assembly
`timescale 1ns/1ps
module filter_serial_control_port (
   input wire logic clock, // System clock, 10 MHz
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic serialClock, // Link shift clock from the host
   input wire logic serialLoadEnable, // Load enable from the host
   input wire logic serialDataIn, // Serial data from the host
   output logic [6:0] boostCode, // Boost DAC code
   output logic [6:0] cutoffCode, // Cutoff DAC code
   output logic powerUpBit, // One powers the filter up
   output logic boostCodeTopBit, // Boost code bit 6
   output logic cutoffCodeTopBit, // Cutoff code bit 6
   output logic cutoffInRange, // Cutoff code within specified span
   output logic [6:0] boostProgramVoltage, // Boost DAC level, full scale at 127
   output logic [6:0] cutoffProgramVoltage, // Cutoff DAC level
   output logic updateStrobe // One-cycle pulse after each accepted packet
);
   // ---------------------------------------------------------------
   // Link domain shifter
   // ---------------------------------------------------------------
   logic [filter_port_pkg::PACKET_BITS-1:0] shiftPacket;
   logic [filter_port_pkg::BIT_COUNT_W-1:0] shiftCount;

   packet_shifter #(
      .WIDTH(filter_port_pkg::PACKET_BITS)
   ) shifter (
      .serialClock(serialClock),
      .serialLoadEnable(serialLoadEnable),
      .serialDataIn(serialDataIn),
      .packet(shiftPacket),
      .bitCount(shiftCount)
   );

   // ---------------------------------------------------------------
   // Enable synchroniser and fall detect
   // ---------------------------------------------------------------
   // The link clock stops when the frame ends, so the enable fall is
   // seen in the system domain; the packet is stable by then.
   logic enableMeta;
   logic enableSync;
   logic enableLast;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         enableMeta <= 1'b0;
         enableSync <= 1'b0;
         enableLast <= 1'b0;
      end else begin
         enableMeta <= serialLoadEnable;
         enableSync <= enableMeta;
         enableLast <= enableSync;
      end
   end

   logic enableFell;
   assign enableFell = enableLast && !enableSync;

   // Packet word crosses as a whole once the enable has settled low
   logic [filter_port_pkg::PACKET_BITS-1:0] packetMeta;
   logic [filter_port_pkg::PACKET_BITS-1:0] packetSync;
   logic [filter_port_pkg::BIT_COUNT_W-1:0] countMeta;
   logic [filter_port_pkg::BIT_COUNT_W-1:0] countSync;
   always_ff @(posedge clock) begin
      packetMeta <= shiftPacket;
      packetSync <= packetMeta;
      countMeta <= shiftCount;
      countSync <= countMeta;
   end

   // ---------------------------------------------------------------
   // Packet decode
   // ---------------------------------------------------------------
   logic [2:0] packetAddr;
   logic [3:0] packetData;
   logic packetWhole;
   assign packetAddr = packetSync[filter_port_pkg::ADDR_MSB:filter_port_pkg::ADDR_LSB];
   assign packetData = packetSync[filter_port_pkg::DATA_MSB:filter_port_pkg::DATA_LSB];
   assign packetWhole = countSync >= 4'(filter_port_pkg::PACKET_BITS);

   // Latch takes effect after the data word has had two syncing edges
   logic latchPending;
   logic latchNow;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         latchPending <= 1'b0;
         latchNow <= 1'b0;
      end else begin
         latchPending <= enableFell;
         latchNow <= latchPending;
      end
   end

   // ---------------------------------------------------------------
   // Nibble registers, no reset value
   // ---------------------------------------------------------------
   logic [3:0] boostUpperNibble;
   logic [3:0] boostLowerNibble;
   logic [3:0] cutoffUpperNibble;
   logic [3:0] cutoffLowerNibble;
   logic [3:0] powerControl;
   logic accepted;

   // Write the addressed nibble; unknown addresses leave all alone
   always_ff @(posedge clock) begin
      accepted <= 1'b0;
      if (latchNow && packetWhole) begin
         case (packetAddr)
            filter_port_pkg::ADDR_BOOST_UPPER: begin
               boostUpperNibble <= packetData;
               accepted <= 1'b1;
            end
            filter_port_pkg::ADDR_BOOST_LOWER: begin
               boostLowerNibble <= packetData;
               accepted <= 1'b1;
            end
            filter_port_pkg::ADDR_CUTOFF_UPPER: begin
               cutoffUpperNibble <= packetData;
               accepted <= 1'b1;
            end
            filter_port_pkg::ADDR_CUTOFF_LOWER: begin
               cutoffLowerNibble <= packetData;
               accepted <= 1'b1;
            end
            filter_port_pkg::ADDR_POWER: begin
               powerControl <= packetData;
               accepted <= 1'b1;
            end
            default: begin
               accepted <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Code assembly, registered one clock after the nibble write
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      boostCode <= {boostUpperNibble[2:0], boostLowerNibble};
      cutoffCode <= {cutoffUpperNibble[2:0], cutoffLowerNibble};
      powerUpBit <= powerControl[0];
      updateStrobe <= sys_rst ? 1'b0 : accepted;
   end

   // DAC levels and flags follow the assembled codes
   assign boostProgramVoltage = boostCode;
   assign cutoffProgramVoltage = cutoffCode;
   assign boostCodeTopBit = boostCode[6];
   assign cutoffCodeTopBit = cutoffCode[6];
   assign cutoffInRange = cutoffCode >= filter_port_pkg::CUTOFF_CODE_MIN;
endmodule : filter_serial_control_port

/* File: tb/filter_port_properties.sv */
// Concurrent checks on the filter port outputs
`timescale 1ns/1ps
module filter_port_properties (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic serialLoadEnable,
   input wire logic [6:0] boostCode,
   input wire logic [6:0] cutoffCode,
   input wire logic powerUpBit,
   input wire logic boostCodeTopBit,
   input wire logic cutoffCodeTopBit,
   input wire logic cutoffInRange,
   input wire logic [6:0] boostProgramVoltage,
   input wire logic updateStrobe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   property p_bdac; boostProgramVoltage === boostCode; endproperty
   a_bdac: assert property (p_bdac) else $error("boost level");
   property p_btop; boostCodeTopBit === boostCode[6]; endproperty
   a_btop: assert property (p_btop) else $error("boost top");
   property p_ctop; cutoffCodeTopBit === cutoffCode[6]; endproperty
   a_ctop: assert property (p_ctop) else $error("cutoff top");
   property p_range; cutoffInRange === (cutoffCode >= 7'h15); endproperty
   a_range: assert property (p_range) else $error("cutoff range");
   property p_pulse; updateStrobe |=> !updateStrobe; endproperty
   a_pulse: assert property (p_pulse) else $error("strobe width");
   property p_hold; $changed(boostCode) || $changed(cutoffCode) |-> updateStrobe; endproperty
   a_hold: assert property (p_hold) else $error("code moved");
   property p_pwr; $changed(powerUpBit) |-> updateStrobe; endproperty
   a_pwr: assert property (p_pwr) else $error("power moved");
   property p_order; updateStrobe |-> $past(!serialLoadEnable, 3); endproperty
   a_order: assert property (p_order) else $error("early update");
endmodule : filter_port_properties
bind filter_serial_control_port filter_port_properties props_u (.clock(clock), .sys_rst(sys_rst),
   .serialLoadEnable(serialLoadEnable), .boostCode(boostCode), .cutoffCode(cutoffCode),
   .powerUpBit(powerUpBit), .boostCodeTopBit(boostCodeTopBit), .cutoffCodeTopBit(cutoffCodeTopBit),
   .cutoffInRange(cutoffInRange), .boostProgramVoltage(boostProgramVoltage), .updateStrobe(updateStrobe));

/* File: tb/serial_host_model.sv */
// Host controller model driving the three-wire link
`timescale 1ns/1ps
module serial_host_model (
   output logic serialClock, // Idle high, runs only in frames
   output logic serialLoadEnable, // Frame enable
   output logic serialDataIn // Serial data
);
   initial begin
      serialClock = 1'b1;
      serialLoadEnable = 1'b0;
      serialDataIn = 1'b0;
   end
   // Send the top n bits of a packet; slow stretches each half period
   task automatic send(input logic [7:0] pkt, input int n, input int slow);
      #7 serialLoadEnable = 1'b1;
      for (int i = 7; i > 7 - n; i--) begin
         serialDataIn = pkt[i];
         #(15 + slow) serialClock = 1'b0;
         #(15 + slow) serialClock = 1'b1;
      end
      #15 serialLoadEnable = 1'b0;
      serialDataIn = ~serialDataIn; // Released line keeps no stale value
   endtask : send
endmodule : serial_host_model

/* File: tb/testbench.sv */
// Self-checking bench for the filter serial control port
`timescale 1ns/1ps
module testbench;
   logic clock, sys_rst, serialClock, serialLoadEnable, serialDataIn, powerUpBit;
   logic boostCodeTopBit, cutoffCodeTopBit, cutoffInRange, updateStrobe;
   logic [6:0] boostCode, cutoffCode, boostProgramVoltage, cutoffProgramVoltage;
   logic [3:0] regs [8];
   logic [7:0] corner [9] = '{8'h87, 8'h1f, 8'h29, 8'h35, 8'h34, 8'hfe, 8'h71, 8'h57, 8'hc2};
   int errors, num_checks;
   bit armed;
   serial_host_model host_u (.serialClock(serialClock), .serialLoadEnable(serialLoadEnable),
      .serialDataIn(serialDataIn));
   filter_serial_control_port dut_u (.clock(clock), .sys_rst(sys_rst), .serialClock(serialClock),
      .serialLoadEnable(serialLoadEnable), .serialDataIn(serialDataIn), .boostCode(boostCode),
      .cutoffCode(cutoffCode), .powerUpBit(powerUpBit), .boostCodeTopBit(boostCodeTopBit),
      .cutoffCodeTopBit(cutoffCodeTopBit), .cutoffInRange(cutoffInRange), .updateStrobe(updateStrobe),
      .boostProgramVoltage(boostProgramVoltage), .cutoffProgramVoltage(cutoffProgramVoltage));
   // Compare and count
   task automatic chk(input string name, input logic [6:0] seen, input logic [6:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // Send one packet, watch for the strobe, then compare the codes, cutoff level, power bit and range flag
   task automatic wr(input logic [7:0] pkt, input int n, input int slow);
      bit hit;
      bit def;
      logic [6:0] cut;
      hit = 1'b0;
      def = (n == 8) && (pkt[6:4] < 3'h4 || pkt[6:4] == 3'h7);
      host_u.send(pkt, n, slow);
      repeat (12) begin
         @(posedge clock);
         #1 hit |= (updateStrobe === 1'b1);
      end
      if (def) regs[pkt[6:4]] = pkt[3:0];
      cut = {regs[2][2:0], regs[3]};
      if (armed) begin
         chk("strobe", 7'(hit), 7'(def));
         chk("boost", boostCode, {regs[0][2:0], regs[1]});
         chk("cutoff", cutoffCode, cut);
         chk("cutoff level", cutoffProgramVoltage, cut);
         chk("power", 7'(powerUpBit), 7'(regs[7][0]));
         chk("range", 7'(cutoffInRange), 7'(cut >= 7'h15));
      end
   endtask : wr
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run
   // System clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      void'($urandom(32'hf08e62bc));
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clock);
      for (int i = 0; i < 8; i++) wr({1'(i), 3'(i), 4'h9}, 8, 0);
      armed = 1'b1;
      chk("boost start", boostCode, 7'h19);
      $display("test program done");
      foreach (corner[i]) wr(corner[i], 8, i);
      $display("test corner done");
      wr(8'h0a, 7, 3);
      wr(8'h3f, 1, 0);
      $display("test short done");
      repeat (24) wr(8'($urandom), 8, $urandom_range(0, 25));
      $display("test random done");
      complete_run();
   end
endmodule : testbench
